// >>> rtl/lpmc_regs.svh
// constants for the low-power mode controller
// Contract
// RL1 - low-power run/sleep: low-power regulator, no PLL, radio and RANDOM_NUMBER_GENERATOR off
// RL2 - sleep modes halt CPU, memories powered, resume within 9 cycles
// RL3 - stop modes: flash off, SRAM kept, others frozen, 1.7/4.7 us wake
// RL4 - stop modes limit clocks and wake sources to the listed set
// RL5 - standby: regulator off unless retention, few blocks, 51 us wake
// RL6 - shutdown: only crystal clock and RTC live, wake by two pins or RTC
// RL7 - pull settings held in shutdown are dropped on leaving shutdown
// RL8 - serial ports keep receiving in stop and raise wake events
// RL9 - two-wire port address match wakes from stop
// RL10 - radio need turns on 32 MHz crystal clock, even in stop
// RL11 - peripheral request turns on 16 MHz RC clock, even in stop
// RL12 - flash power-down in run/sleep only with radio idle, code in SRAM
// RL13 - two SRAM bank clocks gate independently in sleep modes
// RL14 - all I/O analog with Schmitt trigger off during and after reset
// RL15 - internal reset source turns off reset pin pull-up
// RL16 - software picks mode first; gating applies only after CPU halts
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH
`define LPMC_CLK_MHZ 200
`define LPMC_SLEEP_WAKE_CYC 9
`define LPMC_STOP0_WAKE_NS 1700
`define LPMC_STOP1_WAKE_NS 4700
`define LPMC_STBY_WAKE_NS 51000
`define LPMC_STOP0_CYC ((`LPMC_STOP0_WAKE_NS * `LPMC_CLK_MHZ) / 1000)
`define LPMC_STOP1_CYC ((`LPMC_STOP1_WAKE_NS * `LPMC_CLK_MHZ) / 1000)
`define LPMC_STBY_CYC ((`LPMC_STBY_WAKE_NS * `LPMC_CLK_MHZ) / 1000)
`define LPMC_WAKE_W 14
`define LPMC_SRC_W 14
`endif

// >>> rtl/lpmc_pkg.sv
// types for the low-power mode controller
`default_nettype none
package lpmc_pkg;
    typedef enum logic [2:0] {
        LPMC_SEL_SLEEP, LPMC_SEL_LOW_POWER_SLEEP_MODE, LPMC_SEL_STOP0, LPMC_SEL_STOP1,
        LPMC_SEL_STANDBY, LPMC_SEL_SHUTDOWN
    } lpmc_sel_t;
    typedef enum logic [3:0] {
        LPMC_RUN, LPMC_LOW_POWER_RUN_MODE, LPMC_SLEEP, LPMC_LOW_POWER_SLEEP_MODE, LPMC_STOP0,
        LPMC_STOP1, LPMC_STANDBY, LPMC_SHUTDOWN, LPMC_WAKING
    } lpmc_state_t;
endpackage : lpmc_pkg
`default_nettype wire

// >>> rtl/lpmc_ctrl.sv
// low-power mode controller: mode sequencing, gating and wake-up routing
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_regs.svh"
module lpmc_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] modeSelect,
    input wire logic lowPowerRunReq,
    input wire logic cpuSleepEntry,
    input wire logic cpuHalted,
    input wire logic sramRetain,
    input wire logic interruptOrEvent,
    input wire logic [`LPMC_SRC_W-1:0] stopWakeSrc,
    input wire logic wakePinA,
    input wire logic wakePinB,
    input wire logic resetPin,
    input wire logic brownoutWake,
    input wire logic rtcWake,
    input wire logic watchdogWake,
    input wire logic serialStartBit,
    input wire logic serialAddrMatch,
    input wire logic serialFrameDone,
    input wire logic lpSerialStartBit,
    input wire logic lpSerialAddrMatch,
    input wire logic lpSerialFrameDone,
    input wire logic twoWireAddrMatch,
    input wire logic radioNeed,
    input wire logic rcClockReq,
    input wire logic flashPowerDownReq,
    input wire logic radioInUse,
    input wire logic codeInSram,
    input wire logic sramOneGateReq,
    input wire logic sramTwoGateReq,
    input wire logic internalResetSource,
    input wire logic [1:0] shutdownPullCfg,
    output logic useLowPowerRegulator,
    output logic regulatorOff,
    output logic pllAllowed,
    output logic radioRngEnable,
    output logic cpuRun,
    output logic flashPowered,
    output logic sramPowered,
    output logic sramBankOneClkEn,
    output logic sramBankTwoClkEn,
    output logic peripheralsFrozen,
    output logic stopDomainAlive,
    output logic crystalClockEn,
    output logic rcClockEn,
    output logic lowSpeedRcEn,
    output logic serialWakeIrq,
    output logic lpSerialWakeIrq,
    output logic twoWireWakeIrq,
    output logic ioAnalogState,
    output logic resetPinPullUpEn,
    output logic [1:0] ioPullCfg,
    output logic wakeDone
);
    lpmc_pkg::lpmc_state_t state;
    lpmc_pkg::lpmc_state_t next_state;
    logic [`LPMC_SRC_W-1:0] srcMeta;
    logic [`LPMC_SRC_W-1:0] srcSync;
    logic [12:0] pinMeta;
    logic [12:0] pinSync;
    logic [`LPMC_WAKE_W-1:0] wakeCount;
    logic [`LPMC_WAKE_W-1:0] next_wakeCount;
    logic [`LPMC_WAKE_W-1:0] wakeBudget;
    lpmc_pkg::lpmc_state_t lowState;
    logic sleepAwaiting;
    logic sleepy;
    logic isStop;

    // all checks below share the system clock and the reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // stopWakeSrc and the wake pin, reset and peripheral event inputs pass two flops before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srcMeta <= '0;
            srcSync <= '0;
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            srcMeta <= stopWakeSrc;
            srcSync <= srcMeta;
            pinMeta <= {wakePinA, wakePinB, resetPin, brownoutWake, rtcWake,
                watchdogWake, serialStartBit, serialAddrMatch,
                serialFrameDone, lpSerialStartBit, lpSerialAddrMatch,
                lpSerialFrameDone, twoWireAddrMatch};
            pinSync <= pinMeta;
        end
    end

    wire logic sPinA = pinSync[12];
    wire logic sPinB = pinSync[11];
    wire logic sReset = pinSync[10];
    wire logic sBrown = pinSync[9];
    wire logic sRtc = pinSync[8];
    wire logic sWdg = pinSync[7];
    wire logic sUartEv = |pinSync[6:4];
    wire logic sLpUartEv = |pinSync[3:1];
    wire logic sI2cEv = pinSync[0];
    wire logic anyStopWake = (|srcSync) | sReset | sBrown | sRtc | sWdg
        | sUartEv | sLpUartEv | sI2cEv;

    assign isStop = (state == lpmc_pkg::LPMC_STOP0)
        || (state == lpmc_pkg::LPMC_STOP1);
    assign sleepy = (state == lpmc_pkg::LPMC_SLEEP)
        || (state == lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE);

    // mode target and wake budget; gating waits for the halt
    always_comb begin
        next_state = state;
        next_wakeCount = wakeCount;
        wakeBudget = '0;
        case (state)
            lpmc_pkg::LPMC_RUN, lpmc_pkg::LPMC_LOW_POWER_RUN_MODE: begin
                next_state = lowPowerRunReq ? lpmc_pkg::LPMC_LOW_POWER_RUN_MODE
                    : lpmc_pkg::LPMC_RUN;
                // RL16 apply after halt
                if (sleepAwaiting && cpuHalted) begin
                    next_state = lowState;
                end
            end
            lpmc_pkg::LPMC_SLEEP, lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE: begin
                // RL2 sleep wake start
                if (interruptOrEvent) begin
                    next_state = lpmc_pkg::LPMC_WAKING;
                    next_wakeCount = `LPMC_WAKE_W'(`LPMC_SLEEP_WAKE_CYC - 2);
                end
            end
            lpmc_pkg::LPMC_STOP0, lpmc_pkg::LPMC_STOP1: begin
                // RL4 stop wake set
                if (anyStopWake) begin
                    wakeBudget = (state == lpmc_pkg::LPMC_STOP0)
                        ? `LPMC_WAKE_W'(`LPMC_STOP0_CYC)
                        : `LPMC_WAKE_W'(`LPMC_STOP1_CYC);
                    next_state = lpmc_pkg::LPMC_WAKING;
                    // RL3 stop wake time
                    next_wakeCount = wakeBudget - `LPMC_WAKE_W'(1);
                end
            end
            lpmc_pkg::LPMC_STANDBY: begin
                // RL5 standby wake
                if (sReset || sPinA || sPinB || sBrown || sRtc || sWdg) begin
                    next_state = lpmc_pkg::LPMC_WAKING;
                    next_wakeCount = `LPMC_WAKE_W'(`LPMC_STBY_CYC - 1);
                end
            end
            lpmc_pkg::LPMC_SHUTDOWN: begin
                // RL6 shutdown wake set
                if (sPinA || sPinB || sRtc) begin
                    next_state = lpmc_pkg::LPMC_WAKING;
                    next_wakeCount = `LPMC_WAKE_W'(`LPMC_STBY_CYC - 1);
                end
            end
            lpmc_pkg::LPMC_WAKING: begin
                if (wakeCount == '0) begin
                    next_state = lpmc_pkg::LPMC_RUN;
                end else begin
                    next_wakeCount = wakeCount - `LPMC_WAKE_W'(1);
                end
            end
            default: next_state = lpmc_pkg::LPMC_RUN;
        endcase
    end

    // latched target of the pending sleep entry
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sleepAwaiting <= 1'b0;
            lowState <= lpmc_pkg::LPMC_SLEEP;
        end else if (cpuSleepEntry && !sleepAwaiting) begin
            sleepAwaiting <= 1'b1;
            case (lpmc_pkg::lpmc_sel_t'(modeSelect))
                lpmc_pkg::LPMC_SEL_SLEEP: lowState <= lpmc_pkg::LPMC_SLEEP;
                lpmc_pkg::LPMC_SEL_LOW_POWER_SLEEP_MODE:
                    lowState <= lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE;
                lpmc_pkg::LPMC_SEL_STOP0: lowState <= lpmc_pkg::LPMC_STOP0;
                lpmc_pkg::LPMC_SEL_STOP1: lowState <= lpmc_pkg::LPMC_STOP1;
                lpmc_pkg::LPMC_SEL_STANDBY:
                    lowState <= lpmc_pkg::LPMC_STANDBY;
                lpmc_pkg::LPMC_SEL_SHUTDOWN:
                    lowState <= lpmc_pkg::LPMC_SHUTDOWN;
                default: lowState <= lpmc_pkg::LPMC_SLEEP;
            endcase
        end else if (sleepAwaiting && cpuHalted) begin
            sleepAwaiting <= 1'b0;
        end
    end

    // state and wake counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= lpmc_pkg::LPMC_RUN;
            wakeCount <= '0;
        end else begin
            state <= next_state;
            wakeCount <= next_wakeCount;
        end
    end

    // power, regulator and clock gating per mode, all registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            useLowPowerRegulator <= 1'b0;
            regulatorOff <= 1'b0;
            pllAllowed <= 1'b1;
            radioRngEnable <= 1'b1;
            cpuRun <= 1'b1;
            flashPowered <= 1'b1;
            sramPowered <= 1'b1;
            sramBankOneClkEn <= 1'b1;
            sramBankTwoClkEn <= 1'b1;
            peripheralsFrozen <= 1'b0;
            stopDomainAlive <= 1'b1;
            crystalClockEn <= 1'b0;
            rcClockEn <= 1'b0;
            lowSpeedRcEn <= 1'b1;
        end else begin
            // RL1 low-power regulator modes
            useLowPowerRegulator <= (next_state == lpmc_pkg::LPMC_LOW_POWER_RUN_MODE)
                || (next_state == lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE)
                || (next_state == lpmc_pkg::LPMC_STOP1)
                || (next_state == lpmc_pkg::LPMC_STANDBY && sramRetain);
            pllAllowed <= (next_state == lpmc_pkg::LPMC_RUN)
                || (next_state == lpmc_pkg::LPMC_SLEEP);
            radioRngEnable <= (next_state == lpmc_pkg::LPMC_RUN)
                || (next_state == lpmc_pkg::LPMC_SLEEP);
            // RL5 regulator off unless retention
            regulatorOff <= (next_state == lpmc_pkg::LPMC_SHUTDOWN)
                || (next_state == lpmc_pkg::LPMC_STANDBY && !sramRetain);
            // RL2 cpu halted in sleep
            cpuRun <= (next_state == lpmc_pkg::LPMC_RUN)
                || (next_state == lpmc_pkg::LPMC_LOW_POWER_RUN_MODE);
            // RL12 flash power-down guard
            flashPowered <= ((next_state == lpmc_pkg::LPMC_RUN)
                || (next_state == lpmc_pkg::LPMC_LOW_POWER_RUN_MODE)
                || (next_state == lpmc_pkg::LPMC_SLEEP)
                || (next_state == lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE)
                || (next_state == lpmc_pkg::LPMC_WAKING))
                && !(flashPowerDownReq && !radioInUse && codeInSram);
            // RL3 sram kept in stop
            sramPowered <= (next_state != lpmc_pkg::LPMC_SHUTDOWN)
                && !(next_state == lpmc_pkg::LPMC_STANDBY && !sramRetain);
            // RL13 independent bank gates
            sramBankOneClkEn <= !(((next_state == lpmc_pkg::LPMC_SLEEP)
                || (next_state == lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE)) && sramOneGateReq);
            sramBankTwoClkEn <= !(((next_state == lpmc_pkg::LPMC_SLEEP)
                || (next_state == lpmc_pkg::LPMC_LOW_POWER_SLEEP_MODE)) && sramTwoGateReq);
            peripheralsFrozen <= (next_state == lpmc_pkg::LPMC_STOP0)
                || (next_state == lpmc_pkg::LPMC_STOP1);
            stopDomainAlive <= (next_state != lpmc_pkg::LPMC_STANDBY)
                && (next_state != lpmc_pkg::LPMC_SHUTDOWN);
            // RL10 radio needs crystal
            crystalClockEn <= radioNeed
                && (next_state != lpmc_pkg::LPMC_STANDBY)
                && (next_state != lpmc_pkg::LPMC_SHUTDOWN);
            // RL11 rc on request
            rcClockEn <= rcClockReq && ((next_state != lpmc_pkg::LPMC_STANDBY)
                && (next_state != lpmc_pkg::LPMC_SHUTDOWN));
            // RL6 shutdown kills the low-speed rc
            lowSpeedRcEn <= (next_state != lpmc_pkg::LPMC_SHUTDOWN);
        end
    end

    // wake interrupts from serial ports while stopped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serialWakeIrq <= 1'b0;
            lpSerialWakeIrq <= 1'b0;
            twoWireWakeIrq <= 1'b0;
        end else begin
            // RL8 serial wake events
            serialWakeIrq <= isStop && sUartEv;
            lpSerialWakeIrq <= isStop && sLpUartEv;
            // RL9 address match wake
            twoWireWakeIrq <= isStop && sI2cEv;
        end
    end

    // reset-time pin state; pull setting only lives inside shutdown
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ioAnalogState <= 1'b1;
            resetPinPullUpEn <= 1'b1;
            ioPullCfg <= 2'h0;
            wakeDone <= 1'b0;
        end else begin
            // RL14 analog after reset
            ioAnalogState <= ioAnalogState;
            // RL15 internal reset drops pull-up
            resetPinPullUpEn <= !internalResetSource;
            // RL7 drop pulls on exit
            ioPullCfg <= (next_state == lpmc_pkg::LPMC_SHUTDOWN)
                ? shutdownPullCfg : 2'h0;
            wakeDone <= (state == lpmc_pkg::LPMC_WAKING)
                && (next_state == lpmc_pkg::LPMC_RUN);
        end
    end

    // RL2 sleep wake bound
    sleep_wake_a: assert property ( // RL2
        (sleepy && interruptOrEvent) |-> ##[1:9] cpuRun)
        else $error("sleep wake too slow");
    // RL3 stop0 wake within a 330 to 345 cycle window
    stop0_wake_a: assert property ( // RL3
        (state == lpmc_pkg::LPMC_STOP0 && anyStopWake)
        |-> ##[330:345] cpuRun)
        else $error("stop0 wake time wrong");
    // RL1 radio off in lp; outputs land with the state, same edge
    lp_radio_a: assert property ( // RL1
        (state == lpmc_pkg::LPMC_LOW_POWER_RUN_MODE) |-> !radioRngEnable && !pllAllowed)
        else $error("radio on in low-power run");
    // RL7 pulls cleared
    pull_clear_a: assert property ( // RL7
        (state == lpmc_pkg::LPMC_WAKING) |-> ioPullCfg == 2'h0)
        else $error("pull kept after shutdown");
    // RL16 no stop entry before halt
    halt_first_a: assert property ( // RL16
        (!cpuHalted && $past(state) == lpmc_pkg::LPMC_RUN)
        |-> !(state inside {lpmc_pkg::LPMC_STOP0, lpmc_pkg::LPMC_STOP1}))
        else $error("gated before halt");
    // RL15 pull-up follows source
    pullup_src_a: assert property ( // RL15
        internalResetSource |=> !resetPinPullUpEn)
        else $error("reset pull-up on");
    // RL9 two-wire wake
    twowire_wake_a: assert property ( // RL9
        (isStop && sI2cEv) |=> twoWireWakeIrq)
        else $error("two-wire wake missed");
    // RL13 bank gate
    bank_gate_a: assert property ( // RL13
        (state == lpmc_pkg::LPMC_SLEEP && sramOneGateReq && !interruptOrEvent)
        |=> !sramBankOneClkEn)
        else $error("bank one not gated");
endmodule : lpmc_ctrl
`default_nettype wire

// >>> sim/lpmc_cpu_model.sv
// core-side model: runs the sleep entry, halts, resumes on wake
`timescale 1ns/1ps
`default_nettype none
module lpmc_cpu_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sleepCmd,
    input wire logic cpuRun,
    input wire logic wakeDone,
    output logic cpuSleepEntry,
    output logic cpuHalted
);
    logic entered;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpuSleepEntry <= 1'b0;
            entered <= 1'b0;
        end else begin
            cpuSleepEntry <= sleepCmd;
            entered <= sleepCmd;
        end
    end

    // halt after entry
    // halt stays until the controller reports the return to run
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpuHalted <= 1'b0;
        end else if (entered) begin
            cpuHalted <= 1'b1;
        end else if (wakeDone && cpuRun) begin
            cpuHalted <= 1'b0;
        end
    end
endmodule : lpmc_cpu_model
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int STOP0_CYC = 1700 / 5;
    localparam int STOP1_CYC = 4700 / 5;
    localparam int STBY_CYC = 51000 / 5;
    logic clk_sys, rst_n, sleepCmd, cpuSleepEntry, cpuHalted;
    logic lowPowerRunReq, sramRetain, interruptOrEvent, radioNeed, rcClockReq;
    logic flashPowerDownReq, radioInUse, codeInSram, internalResetSource;
    logic sramOneGateReq, sramTwoGateReq;
    logic [2:0] modeSelect;
    logic [1:0] shutdownPullCfg, ioPullCfg;
    logic [13:0] stopWakeSrc;
    logic [12:0] evt;
    logic useLowPowerRegulator, regulatorOff, pllAllowed, radioRngEnable;
    logic cpuRun, flashPowered, sramPowered, sramBankOneClkEn;
    logic sramBankTwoClkEn, peripheralsFrozen, stopDomainAlive;
    logic crystalClockEn, rcClockEn, lowSpeedRcEn, serialWakeIrq;
    logic lpSerialWakeIrq, twoWireWakeIrq, ioAnalogState, resetPinPullUpEn;
    logic wakeDone;
    int n_errors, cmp_count;

    lpmc_ctrl u_lpmc_ctrl (
        .clk_sys, .rst_n, .modeSelect, .lowPowerRunReq, .cpuSleepEntry,
        .cpuHalted, .sramRetain, .interruptOrEvent, .stopWakeSrc,
        .wakePinA(evt[11]), .wakePinB(evt[12]), .resetPin(evt[0]),
        .brownoutWake(evt[1]), .rtcWake(evt[2]), .watchdogWake(evt[3]),
        .serialStartBit(evt[4]), .serialAddrMatch(evt[5]),
        .serialFrameDone(evt[6]), .lpSerialStartBit(evt[7]),
        .lpSerialAddrMatch(evt[8]), .lpSerialFrameDone(evt[9]),
        .twoWireAddrMatch(evt[10]), .radioNeed, .rcClockReq,
        .flashPowerDownReq, .radioInUse, .codeInSram, .sramOneGateReq,
        .sramTwoGateReq, .internalResetSource, .shutdownPullCfg,
        .useLowPowerRegulator, .regulatorOff, .pllAllowed, .radioRngEnable,
        .cpuRun, .flashPowered, .sramPowered, .sramBankOneClkEn,
        .sramBankTwoClkEn, .peripheralsFrozen, .stopDomainAlive,
        .crystalClockEn, .rcClockEn, .lowSpeedRcEn, .serialWakeIrq,
        .lpSerialWakeIrq, .twoWireWakeIrq, .ioAnalogState,
        .resetPinPullUpEn, .ioPullCfg, .wakeDone
    );

    lpmc_cpu_model u_lpmc_cpu_model (
        .clk_sys, .rst_n, .sleepCmd, .cpuRun, .wakeDone, .cpuSleepEntry,
        .cpuHalted
    );

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // sample 1 ns after the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic waitDone(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (wakeDone !== 1'b1 && n < 20000);
    endtask : waitDone

    // mode is set a cycle ahead of the entry, as the core would do
    task automatic goSleep(input logic [2:0] m);
        int n;
        n = 0;
        @(posedge clk_sys);
        modeSelect <= m;
        @(posedge clk_sys);
        sleepCmd <= 1'b1;
        @(posedge clk_sys);
        sleepCmd <= 1'b0;
        while (cpuRun !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        cyc(2);
        chk(cpuRun, 1'b0); // core halted
    endtask : goSleep

    task automatic tRun();
        @(posedge clk_sys);
        flashPowerDownReq <= 1'b1;
        codeInSram <= 1'b1;
        internalResetSource <= 1'b1;
        cyc(3);
        chk(flashPowered, 1'b0); // flash down
        chk(resetPinPullUpEn, 1'b0); // pull-up off
        @(posedge clk_sys);
        radioInUse <= 1'b1;
        internalResetSource <= 1'b0;
        lowPowerRunReq <= 1'b1;
        cyc(3);
        chk(flashPowered, 1'b1); // radio keeps flash
        chk(resetPinPullUpEn, 1'b1); // pull-up back
        chk(useLowPowerRegulator, 1'b1); // small regulator
        chk(pllAllowed, 1'b0); // no pll
        chk(radioRngEnable, 1'b0); // radio off
        @(posedge clk_sys);
        {flashPowerDownReq, codeInSram, radioInUse, lowPowerRunReq} <= '0;
        cyc(3);
        chk(pllAllowed, 1'b1); // pll back
    endtask : tRun

    task automatic tSleep(input logic [2:0] m);
        int n;
        n = 0;
        @(posedge clk_sys);
        sramOneGateReq <= ~m[0];
        sramTwoGateReq <= m[0];
        goSleep(m);
        chk(flashPowered, 1'b1); // flash kept
        chk(sramPowered, 1'b1); // sram kept
        chk(useLowPowerRegulator, m[0]); // regulator pick
        chk(pllAllowed, !m[0]); // pll pick
        chk(radioRngEnable, !m[0]); // radio pick
        chk(sramBankOneClkEn, m[0]); // bank one gate
        chk(sramBankTwoClkEn, !m[0]); // bank two gate
        @(posedge clk_sys);
        interruptOrEvent <= 1'b1;
        while (cpuRun !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        chk(n > 9, 1'b0); // fast resume
        cyc(2);
        @(posedge clk_sys);
        {interruptOrEvent, sramOneGateReq, sramTwoGateReq} <= '0;
    endtask : tSleep

    // idx 13 stands for the grouped stop wake vector, top bit
    task automatic tStop(input logic [2:0] m, input int idx, input int lim);
        int n;
        goSleep(m);
        chk(flashPowered, 1'b0); // flash off
        chk(sramPowered, 1'b1); // sram kept
        chk(peripheralsFrozen, 1'b1); // others frozen
        chk(useLowPowerRegulator, m[0]); // regulator pick
        chk(pllAllowed, 1'b0); // clock set
        chk(stopDomainAlive, 1'b1); // wake domain kept
        @(posedge clk_sys);
        {radioNeed, rcClockReq} <= 2'h3;
        cyc(3);
        chk(crystalClockEn, 1'b1); // crystal on
        chk(rcClockEn, 1'b1); // rc on
        @(posedge clk_sys);
        {radioNeed, rcClockReq} <= 2'h0;
        cyc(3);
        chk(crystalClockEn, 1'b0); // crystal off
        chk(rcClockEn, 1'b0); // rc off
        @(posedge clk_sys);
        if (idx == 13) stopWakeSrc <= 14'h2000;
        else evt[idx] <= 1'b1;
        // irq stands only for the edge that leaves stop: two sync + one
        cyc(3);
        chk(serialWakeIrq, idx inside {[4:6]}); // serial event
        chk(lpSerialWakeIrq, idx inside {[7:9]}); // lp serial event
        chk(twoWireWakeIrq, idx == 10); // address match
        waitDone(n);
        chk(n + 3 < lim || n + 3 > lim + 8, 1'b0); // wake time
        @(posedge clk_sys);
        evt <= '0;
        stopWakeSrc <= '0;
    endtask : tStop

    task automatic tDeep(input logic [2:0] m, input logic ret, input int idx);
        int n;
        @(posedge clk_sys);
        sramRetain <= ret;
        shutdownPullCfg <= 2'h2;
        goSleep(m);
        chk(regulatorOff, !ret); // regulator state
        chk(useLowPowerRegulator, ret); // retention keeps it
        chk(sramPowered, ret); // retention
        chk(lowSpeedRcEn, m == 3'h4); // rc clock
        chk(crystalClockEn, 1'b0); // fast crystal off
        chk(stopDomainAlive, 1'b0); // others off
        chk(ioPullCfg, {m == 3'h5, 1'b0}); // pull held in shutdown
        @(posedge clk_sys);
        evt[idx] <= 1'b1;
        waitDone(n);
        chk(n < STBY_CYC || n > STBY_CYC + 8, 1'b0); // wake time
        if (m == 3'h5) chk(ioPullCfg, 2'h0); // pulls dropped
        @(posedge clk_sys);
        evt <= '0;
        {sramRetain, shutdownPullCfg} <= '0;
    endtask : tDeep

    // bounded run time: longest path is three deep wakes of ~10k cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        conclude();
    end

    initial begin
        {clk_sys, rst_n, sleepCmd, modeSelect, evt, stopWakeSrc} = '0;
        {lowPowerRunReq, sramRetain, interruptOrEvent, radioNeed} = '0;
        {rcClockReq, flashPowerDownReq, radioInUse, codeInSram} = '0;
        {internalResetSource, sramOneGateReq, sramTwoGateReq} = '0;
        shutdownPullCfg = '0;
        cyc(10);
        chk(ioAnalogState, 1'b1); // analog in reset
        chk(resetPinPullUpEn, 1'b1); // pull-up in reset
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(2);
        chk(ioAnalogState, 1'b1); // analog after reset
        tRun();
        tSleep(3'h0);
        tSleep(3'h1);
        for (int i = 0; i < 14; i++) begin
            if (i < 11 || i == 13) tStop(3'h2, i, STOP0_CYC);
        end
        tStop(3'h3, 13, STOP1_CYC);
        tStop(3'h3, 10, STOP1_CYC);
        tDeep(3'h4, 1'b1, 3);
        tDeep(3'h4, 1'b0, 12);
        tDeep(3'h5, 1'b0, 11);
        conclude();
    end
endmodule : testbench
`default_nettype wire
